// ==== hw/psc_pkg.sv ====
// Constants shared by the port statistics counter bank and its classifier.
// Assumes a 25 MHz APB clock and receive reports from MAC logic on it.
package psc_pkg;

    // ------------------------------------------------------------------
    // Counter bank geometry
    // ------------------------------------------------------------------
    localparam int NUM_PORTS = 3;
    localparam int COUNTERS_PER_PORT = 34; // Two of them live elsewhere.
    localparam int SLOTS_PER_PORT = 32;
    localparam int RX_SLOTS = 16;
    localparam int CNT_W = 30;
    localparam int LEN_W = 11;
    localparam int OVF_BIT = 31;
    localparam int VALID_BIT = 30;
    localparam logic [9:0] PORT_SPACE_END = 10'h060;

    // ------------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [9:0] IDX_DATA_LOW = 10'h02C;
    localparam logic [9:0] IDX_DATA_HIGH = 10'h02E;
    localparam logic [9:0] IDX_ACCESS_CTRL = 10'h0C8;
    localparam logic [9:0] IDX_MAX_FRAME = 10'h0D0;

    // ------------------------------------------------------------------
    // Indirect access control word fields
    // ------------------------------------------------------------------
    localparam int CMD_LSB = 10;
    localparam int CMD_MSB = 12;
    localparam logic [2:0] CMD_READ_STATS = 3'h7;
    localparam int IND_ADDR_MSB = 9;

    // ------------------------------------------------------------------
    // Frame size limits and reset values
    // ------------------------------------------------------------------
    localparam logic [LEN_W-1:0] MIN_FRAME = 11'h040;
    localparam logic [LEN_W-1:0] HIST_127 = 11'h07F;
    localparam logic [LEN_W-1:0] DEF_MAX_FRAME = 11'h5F2;
    localparam logic [LEN_W-1:0] MAX_FRAME_LIMIT = 11'h7D0;
    localparam logic [15:0] ACCESS_CTRL_RST = 16'h0000;

    // ------------------------------------------------------------------
    // Receive counter slots
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        PSC_RX_LO_OCTETS, PSC_RX_HI_OCTETS, PSC_RX_SHORT_GOOD,
        PSC_RX_SHORT_BAD, PSC_RX_LONG_GOOD, PSC_RX_LONG_BAD,
        PSC_RX_BAD_SYMBOL, PSC_RX_CHECK_FAIL, PSC_RX_MISALIGNED,
        PSC_RX_MAC_CONTROL, PSC_RX_PAUSE, PSC_RX_BROADCAST,
        PSC_RX_MULTICAST, PSC_RX_UNICAST, PSC_RX_MIN_LENGTH,
        PSC_RX_LEN_65_127
    } psc_slot_t;

endpackage

// ==== hw/psc_classify.sv ====
// Frame classifier: turns one receive frame report into counter strobes.
// Assumes the report fields are stable in the cycle its done pulse is high.
`timescale 1ns/100ps
module psc_classify
    import psc_pkg::*;
(
    input wire logic [LEN_W-1:0] len,
    input wire logic crc_ok,
    input wire logic symbol_err,
    input wire logic odd_bits,
    input wire logic bcast,
    input wire logic mcast,
    input wire logic ctrl_type,
    input wire logic pause_da_ok,
    input wire logic pause_op,
    input wire logic hi_prio,
    input wire logic [LEN_W-1:0] max_len,
    output logic [RX_SLOTS-1:0] inc
);

    logic is_short;
    logic is_long;
    logic legal;
    logic any_err;
    logic good;

    // ------------------------------------------------------------------
    // Size and error classes
    // ------------------------------------------------------------------
    // Odd bits alone do not spoil a legal length frame whose check sequence holds.
    assign is_short = len < MIN_FRAME;
    assign is_long = len > max_len;
    assign legal = !is_short && !is_long;
    assign any_err = !crc_ok || symbol_err;
    assign good = legal && !any_err;

    // One strobe per counter slot; several may fire for one frame.
    always_comb
    begin
        inc = '0;
        // RQ7 octets by priority
        inc[PSC_RX_LO_OCTETS] = !hi_prio;
        inc[PSC_RX_HI_OCTETS] = hi_prio;
        // RQ8 short good frames
        inc[PSC_RX_SHORT_GOOD] = is_short && !any_err;
        // RQ9 short bad frames
        inc[PSC_RX_SHORT_BAD] = is_short && (any_err || odd_bits);
        // RQ10 long good frames
        inc[PSC_RX_LONG_GOOD] = is_long && !any_err;
        // RQ11 long bad frames
        inc[PSC_RX_LONG_BAD] = is_long && (any_err || odd_bits);
        // RQ12 bad symbol frames
        inc[PSC_RX_BAD_SYMBOL] = legal && symbol_err;
        // RQ13 whole byte check fail
        inc[PSC_RX_CHECK_FAIL] = legal && !symbol_err && !odd_bits
                                 && !crc_ok;
        // RQ14 odd bit check fail
        inc[PSC_RX_MISALIGNED] = legal && !symbol_err && odd_bits
                                 && !crc_ok;
        // RQ15 control type frames
        inc[PSC_RX_MAC_CONTROL] = ctrl_type;
        // RQ16 qualified pause frames
        inc[PSC_RX_PAUSE] = ctrl_type && pause_da_ok && pause_op
                            && !is_short && crc_ok;
        // RQ17 good broadcasts
        inc[PSC_RX_BROADCAST] = good && bcast;
        // RQ18 good multicasts
        inc[PSC_RX_MULTICAST] = good && mcast && !bcast && !ctrl_type;
        // RQ19 good unicasts
        inc[PSC_RX_UNICAST] = good && !mcast && !bcast;
        // RQ20 length histogram
        inc[PSC_RX_MIN_LENGTH] = len == MIN_FRAME;
        inc[PSC_RX_LEN_65_127] = (len > MIN_FRAME) && (len <= HIST_127);
    end

endmodule // psc_classify

// ==== hw/psc_counters.sv ====
// Port statistics counter bank with an APB register window.
// Assumes frame reports and auxiliary event strobes come from MAC logic
// clocked by pclk, so they are used without synchronisers.
`timescale 1ns/100ps

// Function
// RQ1: Each switch port keeps its own set of statistics counters.
// RQ2: Read word bit 31 reports counter overflow, reset zero.
// RQ3: Read word bit 30 flags a valid count, reset zero.
// RQ4: Bits 29 to 0 hold the count; reading clears it.
// RQ5: Port counters sit at indirect slots 0x00, 0x20 and 0x40.
// RQ6: Control word starts a read; data returns in two halves.
// RQ7: Slots 0 and 1 count low and high priority octets.
// RQ8: Slot 2 counts short frames with a good check.
// RQ9: Slot 3 counts short frames with any error.
// RQ10: Slot 4 counts long good frames, limit capped at 2000.
// RQ11: Slot 5 counts long frames with any error.
// RQ12: Slot 6 counts legal length frames with a bad symbol.
// RQ13: Slot 7 counts whole byte legal frames with bad check.
// RQ14: Slot 8 counts odd bit legal frames with bad check.
// RQ15: Slot 9 counts MAC control type frames.
// RQ16: Slot 10 counts fully qualified pause frames.
// RQ17: Slot 11 counts good broadcast frames.
// RQ18: Slot 12 counts good multicast, non control frames.
// RQ19: Slot 13 counts good unicast frames.
// RQ20: Slots 14 and 15 count 64 and 65 to 127 octet frames.
// RQ21: Host writes read command plus slot, then reads data halves.
// RQ22: Host rereads from the high half while valid reads zero.
// RQ23: Count wraps on overflow; flag sticks until read clears it.
module psc_counters
    import psc_pkg::*;
#(
    parameter int PORTS = NUM_PORTS
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PORTS-1:0] rx_done,
    input wire logic [PORTS-1:0][LEN_W-1:0] rx_len,
    input wire logic [PORTS-1:0] rx_crc_ok,
    input wire logic [PORTS-1:0] rx_symbol_err,
    input wire logic [PORTS-1:0] rx_odd_bits,
    input wire logic [PORTS-1:0] rx_bcast,
    input wire logic [PORTS-1:0] rx_mcast,
    input wire logic [PORTS-1:0] rx_ctrl_type,
    input wire logic [PORTS-1:0] rx_pause_da_ok,
    input wire logic [PORTS-1:0] rx_pause_op,
    input wire logic [PORTS-1:0] rx_hi_prio,
    input wire logic [PORTS-1:0][SLOTS_PER_PORT-RX_SLOTS-1:0] aux_events
);

    localparam int TOTAL = PORTS * SLOTS_PER_PORT;
    localparam int IDX_W = $clog2(TOTAL);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] cnt_w [TOTAL];
    logic ovf_w [TOTAL];
    logic [15:0] access_ctrl_q;
    logic [LEN_W-1:0] max_frame_q;
    logic [LEN_W-1:0] max_len;
    logic pend_q;
    logic cap_hit_q;
    logic [IDX_W-1:0] cap_idx_q;
    logic valid_q;
    logic [31:0] data_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic apb_acc;
    logic apb_done;
    logic [9:0] req_idx;
    logic [31:0] rd_val;
    logic rd_hit;
    logic [9:0] ind_addr;

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    // Turns a byte address into a register index; low bits must be zero.
    function automatic logic [9:0] reg_index(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:2];
    endfunction

    // True when an address lands on one of the four registers.
    function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
        logic [9:0] i;
        i = reg_index(a);
        return (a[1:0] == 2'h0) &&
               (i == IDX_DATA_LOW || i == IDX_DATA_HIGH ||
                i == IDX_ACCESS_CTRL || i == IDX_MAX_FRAME);
    endfunction

    // Misaligned and unmapped addresses both answer with pslverr set.
    assign req_idx = reg_index(paddr);
    // The first access cycle computes the answer; the second completes.
    assign apb_acc = psel && penable && !pready_q;
    assign apb_done = psel && penable && pready_q;

    // Read multiplexer; unmapped addresses read as zero.
    always_comb
    begin
        rd_val = 32'h0000_0000;
        rd_hit = reg_mapped(paddr);
        if (rd_hit)
        begin
            unique case (req_idx)
                // RQ6 low data half
                IDX_DATA_LOW: rd_val = {16'h0000, data_q[15:0]};
                // RQ6 high data half
                IDX_DATA_HIGH: rd_val = {16'h0000, data_q[OVF_BIT],
                                         valid_q && !pend_q,
                                         data_q[29:16]};
                IDX_ACCESS_CTRL: rd_val = {16'h0000, access_ctrl_q};
                IDX_MAX_FRAME: rd_val = {21'h00_0000, max_frame_q};
                default: rd_val = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // APB slave handshake
    // ------------------------------------------------------------------
    // One wait state keeps every bus output straight from a flip-flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= apb_acc;
            pslverr_q <= apb_acc && !rd_hit;
            if (apb_acc && !pwrite)
            begin
                prdata_q <= rd_val;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------------
    // Frame size limit; writes above the cap are held but clamped in use.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            max_frame_q <= DEF_MAX_FRAME;
        end
        else if (apb_done && pwrite && reg_mapped(paddr) &&
                 req_idx == IDX_MAX_FRAME)
        begin
            max_frame_q <= pwdata[LEN_W-1:0];
        end
    end

    // Clamping on use lets software read back the value it wrote.
    // RQ10 cap at 2000
    assign max_len = (max_frame_q > MAX_FRAME_LIMIT) ? MAX_FRAME_LIMIT
                                                     : max_frame_q;

    // RQ21 control word capture
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            access_ctrl_q <= ACCESS_CTRL_RST;
        end
        else if (apb_done && pwrite && reg_mapped(paddr) &&
                 req_idx == IDX_ACCESS_CTRL)
        begin
            access_ctrl_q <= pwdata[15:0];
        end
    end

    // The slot field of the word being written selects the counter.
    assign ind_addr = pwdata[IND_ADDR_MSB:0];

    // ------------------------------------------------------------------
    // Indirect read sequencing
    // ------------------------------------------------------------------
    // Snapshot and clear share one edge, one cycle after the command.
    // RQ6 read command starts capture
    // A read command raises pend; the next edge copies and clears the slot.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_q <= 1'b0;
            cap_hit_q <= 1'b0;
            cap_idx_q <= '0;
        end
        else
        begin
            if (apb_done && pwrite && reg_mapped(paddr) &&
                req_idx == IDX_ACCESS_CTRL &&
                pwdata[CMD_MSB:CMD_LSB] == CMD_READ_STATS)
            begin
                pend_q <= 1'b1;
                // RQ5 port windows
                cap_hit_q <= ind_addr < PORT_SPACE_END;
                cap_idx_q <= ind_addr[IDX_W-1:0];
            end
            else
            begin
                pend_q <= 1'b0;
            end
        end
    end

    // RQ3 validity flag
    // Valid drops at a new command and rises once the snapshot is taken.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            valid_q <= 1'b0;
            data_q <= 32'h0000_0000;
        end
        else if (pend_q)
        begin
            valid_q <= 1'b1;
            // RQ2 overflow bit
            // RQ4 count field
            // Slots outside the port windows read back as zero apart from the valid flag.
            data_q <= cap_hit_q ? {ovf_w[cap_idx_q], 1'b0,
                                   cnt_w[cap_idx_q]} : 32'h0000_0000;
        end
        else if (apb_done && pwrite && reg_mapped(paddr) &&
                 req_idx == IDX_ACCESS_CTRL)
        begin
            valid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Counter storage
    // ------------------------------------------------------------------
    // RQ1 per port counter sets
    for (genvar p = 0; p < PORTS; p++)
    begin : g_port
        logic [RX_SLOTS-1:0] rx_inc;

        psc_classify u_classify (
            .len(rx_len[p]),
            .crc_ok(rx_crc_ok[p]),
            .symbol_err(rx_symbol_err[p]),
            .odd_bits(rx_odd_bits[p]),
            .bcast(rx_bcast[p]),
            .mcast(rx_mcast[p]),
            .ctrl_type(rx_ctrl_type[p]),
            .pause_da_ok(rx_pause_da_ok[p]),
            .pause_op(rx_pause_op[p]),
            .hi_prio(rx_hi_prio[p]),
            .max_len(max_len),
            .inc(rx_inc)
        );

        for (genvar s = 0; s < SLOTS_PER_PORT; s++)
        begin : g_slot
            localparam int IDX = p * SLOTS_PER_PORT + s;
            logic ev;
            logic [CNT_W:0] amt;
            logic [CNT_W:0] sum;
            logic clr;
            logic [CNT_W-1:0] cnt_q;
            logic ovf_q;

            if (s < RX_SLOTS)
            begin : g_rx
                assign ev = rx_done[p] && rx_inc[s];
            end
            else
            begin : g_aux
                assign ev = aux_events[p][s-RX_SLOTS];
            end

            // RQ7 octet counters add length
            if (s == PSC_RX_LO_OCTETS || s == PSC_RX_HI_OCTETS)
            begin : g_octets
                assign amt = {{(CNT_W+1-LEN_W){1'b0}}, rx_len[p]};
            end
            else
            begin : g_frames
                assign amt = {{CNT_W{1'b0}}, 1'b1};
            end

            assign sum = {1'b0, cnt_q} + amt;
            // Clearing on the snapshot edge matters: clearing one cycle
            // later would drop an event that lands between the copy and
            // the clear. An event on the snapshot edge itself becomes the
            // new count, since the copy already holds the old value.
            assign clr = pend_q && cap_hit_q &&
                         cap_idx_q == IDX_W'(IDX);

            // RQ4 read clears count
            // An event in the clearing cycle survives as the new count.
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    cnt_q <= '0;
                    ovf_q <= 1'b0;
                end
                else if (clr)
                begin
                    cnt_q <= ev ? amt[CNT_W-1:0] : '0;
                    ovf_q <= 1'b0;
                end
                else if (ev)
                begin
                    // RQ23 wrap and flag
                    cnt_q <= sum[CNT_W-1:0];
                    if (sum[CNT_W])
                    begin
                        ovf_q <= 1'b1;
                    end
                end
            end

            assign cnt_w[IDX] = cnt_q;
            assign ovf_w[IDX] = ovf_q;
        end
    end

endmodule // psc_counters

// ==== verif/psc_counters_monitor.sv ====
// Checker for the APB side of the port statistics counter bank.
// Assumes it is bound to psc_counters and sees only its bus ports.
`timescale 1ns/100ps
module psc_counters_monitor
    import psc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic cmd_seen_q;

    // Tracks whether the last control write was a read command; any other
    // control write drops valid without a new snapshot.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmd_seen_q <= 1'b0;
        else if (psel && penable && pready && pwrite && !pslverr &&
                 paddr == {IDX_ACCESS_CTRL, 2'b00})
            cmd_seen_q <= pwdata[CMD_MSB:CMD_LSB] == CMD_READ_STATS;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_ONE_WAIT: assert property (
        psel && !penable ##1 psel && penable |=> pready)
        else $error("pready missing after one wait state");
    AST_READY_PULSE: assert property (
        pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_READY_CAUSE: assert property (
        pready |-> $past(psel && penable))
        else $error("pready without an access phase");
    AST_MISALIGNED: assert property (
        pready && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    AST_ERR_ZERO: assert property (
        pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");
    AST_ERR_READY: assert property (
        pslverr |-> pready)
        else $error("pslverr outside the answer cycle");
    AST_DATA_HOLDS: assert property (
        !(psel && penable && !pwrite) |=> $stable(prdata))
        else $error("read data changed without a read");
    AST_VALID_HIGH: assert property (
        pready && !pwrite && !pslverr && cmd_seen_q &&
        paddr == {IDX_DATA_HIGH, 2'b00} |-> prdata[VALID_BIT-16])
        else $error("valid flag low after a completed command");
endmodule // psc_counters_monitor

// ==== verif/psc_mac_model.sv ====
// Behavioural receive MAC that reports frames to the counter bank.
// Assumes one bench process calls its tasks at a time.
`timescale 1ns/100ps
module psc_mac_model
    import psc_pkg::*;
(
    input wire logic pclk,
    output logic [NUM_PORTS-1:0] rx_done,
    output logic [NUM_PORTS-1:0][LEN_W-1:0] rx_len,
    output logic [8:0][NUM_PORTS-1:0] rx_flags,
    output logic [NUM_PORTS-1:0][15:0] aux_events
);
    // Quiet lines at start; flag bit 0 is the good check.
    initial
    begin
        rx_done = '0;
        rx_len = '0;
        rx_flags = '0;
        aux_events = '0;
    end

    // One report pulse; fields flip afterwards so stale values show.
    task automatic frame(input int p, input logic [10:0] l,
                         input logic [8:0] f);
        @(posedge pclk);
        rx_done[p] <= 1'b1;
        rx_len[p] <= l;
        for (int k = 0; k < 9; k++)
            rx_flags[k][p] <= f[k];
        @(posedge pclk);
        rx_done[p] <= 1'b0;
        rx_len[p] <= ~l;
        for (int k = 0; k < 9; k++)
            rx_flags[k][p] <= ~f[k];
    endtask

    // Single strobe on one auxiliary event line.
    task automatic aux(input int p, input int i);
        @(posedge pclk);
        aux_events[p][i] <= 1'b1;
        @(posedge pclk);
        aux_events[p][i] <= 1'b0;
    endtask
endmodule // psc_mac_model

// ==== verif/tb.sv ====
// Self-checking bench for the port statistics counter bank.
// Assumes the package is compiled first; APB and frames run on pclk.
`timescale 1ns/100ps
module tb
    import psc_pkg::*;
;
    localparam logic [11:0] A_LO = {IDX_DATA_LOW, 2'b00};
    localparam logic [11:0] A_HI = {IDX_DATA_HIGH, 2'b00};
    localparam logic [11:0] A_CTRL = {IDX_ACCESS_CTRL, 2'b00};
    localparam logic [11:0] A_MAX = {IDX_MAX_FRAME, 2'b00};
    localparam logic [8:0] FC = 9'h001;
    localparam logic [8:0] FS = 9'h002;
    localparam logic [8:0] FO = 9'h004;
    localparam logic [8:0] FB = 9'h008;
    localparam logic [8:0] FM = 9'h010;
    localparam logic [8:0] FQ = 9'h0E0;
    localparam logic [8:0] FH = 9'h100;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, w;
    logic [2:0] done;
    logic [2:0][10:0] len;
    logic [8:0][2:0] fl;
    logic [2:0][15:0] aux;
    int err_count = 0;
    int total_checks = 0;
    int exp_cnt [2][16] = '{
        '{255, 100, 0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 2, 2},
        '{3580, 0, 1, 1, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0, 0, 3}};

    psc_counters i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_done(done),
        .rx_len(len), .rx_crc_ok(fl[0]), .rx_symbol_err(fl[1]),
        .rx_odd_bits(fl[2]), .rx_bcast(fl[3]), .rx_mcast(fl[4]),
        .rx_ctrl_type(fl[5]), .rx_pause_da_ok(fl[6]), .rx_pause_op(fl[7]),
        .rx_hi_prio(fl[8]), .aux_events(aux));
    psc_mac_model i_mac (.pclk(pclk), .rx_done(done), .rx_len(len),
        .rx_flags(fl), .aux_events(aux));

    // ------------------------------------------------------------------
    // Bus and comparison tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n == 20)
            err_count++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // command word, then high half (retried while not valid), low half.
    task automatic rd_cnt(input logic [9:0] slot, output logic [31:0] v);
        logic [31:0] hi, lo;
        logic e;
        int n;
        apb(1'b1, A_CTRL, {19'h0, CMD_READ_STATS, slot}, lo, e);
        n = 0;
        do
        begin
            apb(1'b0, A_HI, 32'h0, hi, e);
            n++;
        end
        while (hi[14] !== 1'b1 && n < 4);
        apb(1'b0, A_LO, 32'h0, lo, e);
        v = {hi[15:0], lo[15:0]};
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // The run needs about five hundred cycles; forty times that is a hang.
    initial
    begin
        #800000;
        err_count++;
        end_sim();
    end

    initial
    begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_MAX, 32'h0, w, err);
        chk(w, {21'h0, DEF_MAX_FRAME});
        apb(1'b0, A_CTRL, 32'h0, w, err);
        chk(w, {16'h0, ACCESS_CTRL_RST});
        apb(1'b0, 12'h004, 32'h0, w, err);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h0B9, 32'h0, w, err);
        chk({31'h0, err}, 32'h1);
        rd_cnt(10'h00E, w);
        chk(w, 32'h4000_0000);
        // Good frames on the first port, faulty ones on the second.
        i_mac.frame(0, 11'h040, FC);
        i_mac.frame(0, 11'h064, FC | FB | FH);
        i_mac.frame(0, 11'h07F, FC | FM);
        i_mac.frame(0, 11'h040, FC | FM | FQ);
        i_mac.frame(1, 11'h028, FC);
        i_mac.frame(1, 11'h028, 9'h000);
        i_mac.frame(1, 11'h640, FC);
        i_mac.frame(1, 11'h640, 9'h000);
        i_mac.frame(1, 11'h064, FC | FS);
        i_mac.frame(1, 11'h064, 9'h000);
        i_mac.frame(1, 11'h064, FO);
        // No frame on the second port is clean, so its unicast stays zero.
        for (int p = 0; p < 2; p++)
            for (int s = 0; s < 16; s++)
            begin
                rd_cnt(10'(p * 32 + s), w);
                chk(w, {2'b01, 30'(exp_cnt[p][s])});
            end
        rd_cnt(10'h000, w);
        chk(w, 32'h4000_0000);
        apb(1'b1, A_MAX, 32'h0000_0064, w, err);
        i_mac.frame(2, 11'h07F, FC);
        rd_cnt(10'h044, w);
        chk(w, 32'h4000_0001);
        apb(1'b1, A_MAX, 32'h0000_07FF, w, err);
        i_mac.frame(2, 11'h7CF, FC);
        i_mac.frame(2, 11'h7D1, FC);
        rd_cnt(10'h044, w);
        chk(w, 32'h4000_0001);
        i_mac.aux(2, 3);
        // A command other than read stores the word and drops valid but clears no counter.
        apb(1'b1, A_CTRL, 32'h0000_0C53, w, err);
        apb(1'b0, A_CTRL, 32'h0, w, err);
        chk(w, 32'h0000_0C53);
        rd_cnt(10'h053, w);
        chk(w, 32'h4000_0001);
        rd_cnt(10'h060, w);
        chk(w, 32'h4000_0000);
        end_sim();
    end
endmodule // tb

bind psc_counters psc_counters_monitor i_mon (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
